// >>> rtl/slot_check.sv
// peripheral slot decoder: says whether an address falls in a bus space and hits a populated slot
`timescale 1ns/10ps
`default_nettype none

module slot_check #(
  parameter logic [vrad_pkg::SLOT_COUNT-1:0] SLOTS = '0
) (
  input  wire logic [31:0] addr,
  input  wire logic [31:0] space_base,
  input  wire logic [31:0] space_end,
  output logic             in_space,
  output logic             populated
);
  import vrad_pkg::*;

  logic [SLOT_COUNT-1:0] hit;
  logic [SLOT_BITS-1:0]  slot;

  assign slot     = addr[SLOT_LSB +: SLOT_BITS];
  assign in_space = (addr >= space_base) && (addr <= space_end);

  // one comparator per slot of 16 kB
  genvar i;
  generate
    for (i = 0; i < SLOT_COUNT; i = i + 1)
    begin : g_slot
      assign hit[i] = (slot == SLOT_BITS'(i)) && SLOTS[i]; // (R17)
    end
  endgenerate

  assign populated = in_space && (|hit);

endmodule
`default_nettype wire

// >>> rtl/vector_remap_abort_decoder.sv
// vector remap and abort decoder placed between the core and the memory targets
//
// Function
// (R1) eight exception vectors sit at word slots from zero, fast interrupt at the top
// (R2) the remapped window covers 64 bytes from zero up to its top address
// (R3) every reset selects boot loader mapping, boot block vectors at the bottom
// (R4) user flash mapping leaves the window on flash; absent on flashless parts
// (R5) user RAM mapping redirects the window to the bottom of SRAM
// (R6) a low boot pin at reset release selects external mapping, if memory controller
// (R7) remapped regions stay reachable at their original addresses too
// (R8) boot block at top of on-chip space; other regions fixed in every mode
// (R9) the range between flash end and SRAM aborts
// (R10) the gap between SRAM top and the boot block aborts
// (R11) boot block to peripheral space aborts, except external memory where present
// (R12) reserved bus space and unpopulated peripheral slots abort
// (R13) data accesses get data abort, fetches get prefetch abort
// (R14) any fetch from either peripheral space gets a prefetch abort
// (R15) undefined offsets inside a populated slot do not abort
// (R16) prefetch abort travels with the fetched word; core acts only on execution
// (R17) each peripheral space is 128 slots of 16 kB
// (R18) mapping mode lives in a writable register field, reset to boot loader
// (R19) abort decided in the address cycle; aborted access never reaches a target
`timescale 1ns/10ps
`default_nettype none

module vector_remap_abort_decoder #(
  parameter logic                              HAS_FLASH  = 1'b1,
  parameter logic                              FLASH_256K = 1'b1,
  parameter logic                              HAS_EMC    = 1'b1,
  parameter logic [vrad_pkg::SLOT_COUNT-1:0]   APB_SLOTS  = vrad_pkg::APB_SLOTS_DEFAULT,
  parameter logic [vrad_pkg::SLOT_COUNT-1:0]   AHB_SLOTS  = vrad_pkg::AHB_SLOTS_DEFAULT
) (
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire logic [1:0]           boot_source_pins,
  input  wire logic                 acc_valid,
  input  wire logic                 acc_fetch,
  input  wire logic                 acc_write,
  input  wire logic [31:0]          acc_addr,
  input  wire logic [31:0]          acc_wdata,
  output logic                      tgt_valid,
  output logic                      tgt_write,
  output logic [31:0]               tgt_addr,
  output logic [31:0]               tgt_wdata,
  output logic                      resp_valid,
  output logic [31:0]               resp_rdata,
  output logic                      data_abort,
  output logic                      prefetch_abort,
  output vrad_pkg::map_mode_t       map_mode
);
  import vrad_pkg::*;

  typedef struct packed {
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    logic [1:0]  sync3;
    logic [1:0]  strap_cnt;
    logic        strap_done;
    map_mode_t   mode;
    logic        tgt_valid;
    logic        tgt_write;
    logic [31:0] tgt_addr;
    logic [31:0] tgt_wdata;
    logic        resp_valid;
    logic [31:0] resp_rdata;
    logic        data_abort;
    logic        prefetch_abort;
  } state_t;

  localparam state_t STATE_RESET = '{
    sync1:          PINS_RESET,
    sync2:          PINS_RESET,
    sync3:          PINS_RESET,
    strap_cnt:      2'h0,
    strap_done:     1'b0,
    mode:           MAP_SEL_RESET,
    tgt_valid:      1'b0,
    tgt_write:      1'b0,
    tgt_addr:       32'h0000_0000,
    tgt_wdata:      32'h0000_0000,
    resp_valid:     1'b0,
    resp_rdata:     32'h0000_0000,
    data_abort:     1'b0,
    prefetch_abort: 1'b0
  };

  state_t st_r;
  state_t st_nxt;

  logic        apb_in;
  logic        apb_pop;
  logic        ahb_in;
  logic        ahb_pop;
  logic        in_window;
  logic        is_periph;
  logic        region_abort;
  logic        reg_hit;
  logic [31:0] flash_end;
  logic [31:0] win_base;
  logic [31:0] remapped;
  map_mode_t   wr_mode;

  // peripheral slot decode of both bus spaces
  slot_check #(
    .SLOTS      (APB_SLOTS)
  ) u_apb_slots (
    .addr       (acc_addr),
    .space_base (APB_BASE),
    .space_end  (APB_END),
    .in_space   (apb_in),
    .populated  (apb_pop)
  );

  slot_check #(
    .SLOTS      (AHB_SLOTS)
  ) u_ahb_slots (
    .addr       (acc_addr),
    .space_base (AHB_BASE),
    .space_end  (AHB_END),
    .in_space   (ahb_in),
    .populated  (ahb_pop)
  );

  // address classification, evaluated in the address cycle
  always_comb
  begin
    flash_end = FLASH_256K ? FLASH_END_256K : FLASH_END_128K;
    if (!HAS_FLASH)
    begin
      flash_end = VEC_BASE;
    end

    // vector slots 0x00..0x1C plus 32 further bytes
    in_window = (acc_addr <= WIN_TOP); // (R1) (R2)
    is_periph = apb_in || ahb_in;
    reg_hit   = (acc_addr == MAP_SEL_ADDR);

    region_abort = 1'b0;
    if ((acc_addr >= flash_end) && (acc_addr <= RSV_LOW_END) && !in_window)
    begin
      region_abort = 1'b1; // (R9)
    end
    if ((acc_addr >= SRAM_GAP_BASE) && (acc_addr <= SRAM_GAP_END))
    begin
      region_abort = 1'b1; // (R10)
    end
    if ((acc_addr >= EXT_BASE) && (acc_addr <= RSV_HIGH_END))
    begin
      region_abort = !(HAS_EMC && (acc_addr <= EXT_END)); // (R11)
    end
    if ((acc_addr > RSV_HIGH_END) && !is_periph)
    begin
      region_abort = 1'b1; // (R12)
    end
    if (is_periph && !(apb_pop || ahb_pop))
    begin
      region_abort = 1'b1; // (R12)
    end
    // populated slots pass whatever the offset inside them
    if ((apb_pop || ahb_pop) && !reg_hit)
    begin
      region_abort = 1'b0; // (R15)
    end

    // window source follows the mode field; other regions keep their addresses
    case (st_r.mode) // (R18)
      MAP_BOOT:  win_base = BOOT_BASE; // (R3) (R8)
      MAP_FLASH: win_base = VEC_BASE;  // (R4)
      MAP_RAM:   win_base = SRAM_BASE; // (R5)
      MAP_EXT:   win_base = EXT_BASE;  // (R6)
      default:   win_base = BOOT_BASE;
    endcase

    // alias only: original addresses are passed through unchanged
    if (in_window)
    begin
      remapped = {win_base[31:WIN_BITS], acc_addr[WIN_BITS-1:0]}; // (R7)
    end
    else
    begin
      remapped = acc_addr; // (R7) (R8)
    end

    // a mode that the part lacks leaves the field unchanged
    wr_mode = map_mode_t'(acc_wdata[MAP_SEL_MSB:MAP_SEL_LSB]);
    if ((wr_mode == MAP_FLASH) && !HAS_FLASH)
    begin
      wr_mode = st_r.mode; // (R4)
    end
    if ((wr_mode == MAP_EXT) && !HAS_EMC)
    begin
      wr_mode = st_r.mode; // (R6)
    end
  end

  // next state
  always_comb
  begin
    st_nxt = st_r;

    // boot pins pass three flip-flops
    st_nxt.sync1 = boot_source_pins;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync3 = st_r.sync2;

    // strap judged once after reset release, when the last two stages agree
    if (!st_r.strap_done)
    begin
      if (st_r.strap_cnt != STRAP_WAIT)
      begin
        st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
      end
      else if (st_r.sync2 == st_r.sync3)
      begin
        st_nxt.strap_done = 1'b1;
        if (HAS_EMC && (st_r.sync3 != BOOT_PINS_ONCHIP))
        begin
          st_nxt.mode = MAP_EXT; // (R6)
        end
      end
    end

    st_nxt.tgt_valid      = 1'b0;
    st_nxt.resp_valid     = 1'b0;
    st_nxt.data_abort     = 1'b0;
    st_nxt.prefetch_abort = 1'b0;
    st_nxt.resp_rdata     = 32'h0000_0000;

    if (acc_valid)
    begin
      if (acc_fetch && is_periph)
      begin
        // flag travels with the meaningless fetch word, not raised here
        st_nxt.resp_valid     = 1'b1; // (R16)
        st_nxt.prefetch_abort = 1'b1; // (R14) (R19)
      end
      else if (region_abort)
      begin
        st_nxt.resp_valid     = 1'b1; // (R19)
        st_nxt.prefetch_abort = acc_fetch;  // (R13) (R16)
        st_nxt.data_abort     = !acc_fetch; // (R13)
      end
      else if (reg_hit)
      begin
        st_nxt.resp_valid = 1'b1;
        if (acc_write)
        begin
          st_nxt.mode = wr_mode; // (R18)
        end
        else
        begin
          st_nxt.resp_rdata[MAP_SEL_MSB:MAP_SEL_LSB] = st_r.mode; // (R18)
        end
      end
      else
      begin
        st_nxt.tgt_valid = 1'b1;
        st_nxt.tgt_write = acc_write;
        st_nxt.tgt_addr  = remapped; // (R7)
        st_nxt.tgt_wdata = acc_wdata;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_r <= STATE_RESET; // (R3) (R18)
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign tgt_valid      = st_r.tgt_valid;
  assign tgt_write      = st_r.tgt_write;
  assign tgt_addr       = st_r.tgt_addr;
  assign tgt_wdata      = st_r.tgt_wdata;
  assign resp_valid     = st_r.resp_valid;
  assign resp_rdata     = st_r.resp_rdata;
  assign data_abort     = st_r.data_abort;
  assign prefetch_abort = st_r.prefetch_abort;
  assign map_mode       = st_r.mode;

endmodule
`default_nettype wire

// >>> rtl/vrad_pkg.sv
// package: address map, mapping modes and timing constants of the vector remap and abort decoder
package vrad_pkg;

  // memory mapping modes held in the map select register
  typedef enum logic [1:0] {
    MAP_BOOT,
    MAP_FLASH,
    MAP_RAM,
    MAP_EXT
  } map_mode_t;

  // vector area and remapped window
  localparam logic [31:0] VEC_BASE       = 32'h0000_0000;
  localparam logic [31:0] VEC_FIQ        = 32'h0000_001C;
  localparam logic [31:0] WIN_TOP        = 32'h0000_003F;
  localparam int          WIN_BITS       = 6;

  // on-chip flash ends
  localparam logic [31:0] FLASH_END_128K = 32'h0002_0000;
  localparam logic [31:0] FLASH_END_256K = 32'h0004_0000;
  localparam logic [31:0] RSV_LOW_END    = 32'h3FFF_FFFF;

  // sram, reserved gap and boot block
  localparam logic [31:0] SRAM_BASE      = 32'h4000_0000;
  localparam logic [31:0] SRAM_GAP_BASE  = 32'h4000_4000;
  localparam logic [31:0] SRAM_GAP_END   = 32'h7FFF_DFFF;
  localparam logic [31:0] BOOT_BASE      = 32'h7FFF_E000;

  // space above the boot block and external memory
  localparam logic [31:0] EXT_BASE       = 32'h8000_0000;
  localparam logic [31:0] EXT_END        = 32'h83FF_FFFF;
  localparam logic [31:0] RSV_HIGH_END   = 32'hDFFF_FFFF;

  // peripheral bus spaces, 128 slots of 16 kB each
  localparam logic [31:0] APB_BASE       = 32'hE000_0000;
  localparam logic [31:0] APB_END        = 32'hE01F_FFFF;
  localparam logic [31:0] AHB_BASE       = 32'hFFE0_0000;
  localparam logic [31:0] AHB_END        = 32'hFFFF_FFFF;
  localparam int          SLOT_LSB       = 14;
  localparam int          SLOT_BITS      = 7;
  localparam int          SLOT_COUNT     = 128;

  // map select register
  localparam logic [31:0] MAP_SEL_ADDR   = 32'hE01F_C040;
  localparam int          MAP_SEL_LSB    = 0;
  localparam int          MAP_SEL_MSB    = 1;
  localparam map_mode_t   MAP_SEL_RESET  = MAP_BOOT;

  // boot source strap: all pins high selects on-chip boot
  localparam logic [1:0]  BOOT_PINS_ONCHIP = 2'h3;
  localparam logic [1:0]  PINS_RESET       = 2'h3;

  // cycles after reset release before the strap is judged
  localparam logic [1:0]  STRAP_WAIT     = 2'h3;

  // populated peripheral slots
  localparam logic [SLOT_COUNT-1:0] APB_SLOTS_DEFAULT =
    128'h8000_0000_0000_0000_0000_0000_009F_FFBF;
  localparam logic [SLOT_COUNT-1:0] AHB_SLOTS_DEFAULT =
    128'h8000_0000_0000_0000_0000_0000_0000_0000;

endpackage

// >>> tb/core_model.sv
// core model: issues one access at a time and captures the answer
`timescale 1ns/10ps
`default_nettype none

module core_model (
  input  wire logic        mclk,
  output logic             acc_valid,
  output logic             acc_fetch,
  output logic             acc_write,
  output logic [31:0]      acc_addr,
  output logic [31:0]      acc_wdata,
  input  wire logic        tgt_valid,
  input  wire logic [31:0] tgt_addr,
  input  wire logic        resp_valid,
  input  wire logic [31:0] resp_rdata,
  input  wire logic        data_abort,
  input  wire logic        prefetch_abort
);
  logic [3:0]  code;
  logic [31:0] val;

  initial
  begin
    acc_valid = 1'b0;
    acc_fetch = 1'b0;
    acc_write = 1'b0;
    acc_addr  = 32'h0;
    acc_wdata = 32'h0;
  end

  task automatic xfer(input logic f, w, input logic [31:0] a, d);
    @(posedge mclk);
    acc_valid <= 1'b1;
    acc_fetch <= f;
    acc_write <= w;
    acc_addr  <= a;
    acc_wdata <= d;
    @(posedge mclk);
    acc_valid <= 1'b0;
    acc_addr  <= ~a;
    acc_wdata <= ~d;
    #1;
    code = {tgt_valid, resp_valid, data_abort, prefetch_abort};
    val  = tgt_valid ? tgt_addr : resp_rdata;
  endtask
endmodule

`default_nettype wire

// >>> tb/testbench.sv
// testbench: remap modes, abort regions and boot strap of the decoder
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import vrad_pkg::*;
  localparam int FWD = 0, DAB = 1, PAB = 2, REG = 3;
  logic        mclk, reset, acc_valid, acc_fetch, acc_write, tgt_valid, tgt_write;
  logic        resp_valid, data_abort, prefetch_abort;
  logic [1:0]  boot_source_pins;
  logic [31:0] acc_addr, acc_wdata, tgt_addr, tgt_wdata, resp_rdata;
  map_mode_t   map_mode;
  int          failures, checks;

  vector_remap_abort_decoder dut_u (
    .mclk             (mclk),
    .reset            (reset),
    .boot_source_pins (boot_source_pins),
    .acc_valid        (acc_valid),
    .acc_fetch        (acc_fetch),
    .acc_write        (acc_write),
    .acc_addr         (acc_addr),
    .acc_wdata        (acc_wdata),
    .tgt_valid        (tgt_valid),
    .tgt_write        (tgt_write),
    .tgt_addr         (tgt_addr),
    .tgt_wdata        (tgt_wdata),
    .resp_valid       (resp_valid),
    .resp_rdata       (resp_rdata),
    .data_abort       (data_abort),
    .prefetch_abort   (prefetch_abort),
    .map_mode         (map_mode)
  );

  core_model core_u (
    .mclk           (mclk),
    .acc_valid      (acc_valid),
    .acc_fetch      (acc_fetch),
    .acc_write      (acc_write),
    .acc_addr       (acc_addr),
    .acc_wdata      (acc_wdata),
    .tgt_valid      (tgt_valid),
    .tgt_addr       (tgt_addr),
    .resp_valid     (resp_valid),
    .resp_rdata     (resp_rdata),
    .data_abort     (data_abort),
    .prefetch_abort (prefetch_abort)
  );

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic f, w, input logic [31:0] a, d, input int k, input logic [31:0] e);
    logic [3:0] exp_code;
    core_u.xfer(f, w, a, d);
    exp_code = (k == FWD) ? 4'h8 : (k == DAB) ? 4'h6 : (k == PAB) ? 4'h5 : 4'h4;
    chk({28'h0, core_u.code}, {28'h0, exp_code});
    chk(core_u.val, e);
    if (k == FWD)
    begin
      chk({31'h0, tgt_write}, {31'h0, w});
      chk(tgt_wdata, d);
    end
  endtask

  task automatic do_reset(input logic [1:0] pins);
    reset <= 1'b1;
    boot_source_pins <= pins;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    #1;
    chk({30'h0, map_mode}, 32'h0);
  endtask

  task automatic give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    failures = 0;
    checks = 0;
    reset = 1'b1;
    boot_source_pins = 2'h3;
    do_reset(2'h3);
    acc(0, 0, 32'h10, 0, FWD, 32'h7FFF_E010);
    acc(1, 0, VEC_FIQ, 0, FWD, 32'h7FFF_E01C);
    acc(0, 0, 32'h40, 0, FWD, 32'h40);
    acc(0, 0, 32'h7FFF_E010, 0, FWD, 32'h7FFF_E010);
    acc(0, 0, MAP_SEL_ADDR, 0, REG, 0);
    $display("test boot map done");
    acc(0, 1, MAP_SEL_ADDR, 32'hFFFF_FFFE, REG, 0);
    acc(0, 0, MAP_SEL_ADDR, 0, REG, 2);
    acc(0, 0, 32'h3C, 0, FWD, 32'h4000_003C);
    acc(0, 0, SRAM_BASE, 0, FWD, SRAM_BASE);
    acc(0, 1, 32'h4000_0100, 32'hA5A5_5A5A, FWD, 32'h4000_0100);
    acc(0, 1, MAP_SEL_ADDR, 1, REG, 0);
    acc(1, 0, WIN_TOP, 0, FWD, WIN_TOP);
    $display("test modes done");
    acc(0, 0, 32'h3_FFFC, 0, FWD, 32'h3_FFFC);
    acc(0, 0, FLASH_END_256K, 0, DAB, 0);
    acc(1, 0, RSV_LOW_END, 0, PAB, 0);
    acc(0, 1, SRAM_GAP_BASE, 0, DAB, 0);
    acc(1, 0, SRAM_GAP_END, 0, PAB, 0);
    acc(0, 0, BOOT_BASE, 0, FWD, BOOT_BASE);
    acc(0, 0, EXT_END, 0, FWD, EXT_END);
    acc(0, 0, 32'h8400_0000, 0, DAB, 0);
    acc(0, 0, 32'hE001_8000, 0, DAB, 0);
    acc(0, 0, 32'hE000_D000, 0, FWD, 32'hE000_D000);
    acc(1, 0, APB_BASE, 0, PAB, 0);
    acc(1, 0, AHB_END, 0, PAB, 0);
    acc(0, 0, 32'hE020_0000, 0, DAB, 0);
    acc(0, 0, AHB_BASE, 0, DAB, 0);
    $display("test aborts done");
    @(posedge mclk);
    do_reset(2'h1);
    repeat (8) @(posedge mclk);
    #1;
    chk({30'h0, map_mode}, 32'h3);
    acc(0, 0, 32'h20, 0, FWD, 32'h8000_0020);
    $display("test strap done");
    give_verdict;
  end
endmodule

`default_nettype wire

// >>> tb/vrad_checker_assertions.sv
// checker: answer, remap and abort relations at the decoder ports
`timescale 1ns/10ps
`default_nettype none

module vrad_checker (
  input wire logic                mclk,
  input wire logic                reset,
  input wire logic                acc_valid,
  input wire logic                acc_fetch,
  input wire logic                acc_write,
  input wire logic [31:0]         acc_addr,
  input wire logic [31:0]         acc_wdata,
  input wire logic                tgt_valid,
  input wire logic [31:0]         tgt_addr,
  input wire logic                resp_valid,
  input wire logic                data_abort,
  input wire logic                prefetch_abort,
  input wire vrad_pkg::map_mode_t map_mode
);
  import vrad_pkg::*;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  a_one_answer: assert property (acc_valid |=> tgt_valid ^ resp_valid)
    else $error("access not answered exactly once");
  a_idle_quiet: assert property (!acc_valid |=> !tgt_valid && !resp_valid)
    else $error("answer without access");
  a_fetch_periph: assert property (acc_valid && acc_fetch && (acc_addr[31:21] == 11'h700 ||
    acc_addr[31:21] == 11'h7FF) |=> resp_valid && prefetch_abort && !tgt_valid)
    else $error("peripheral fetch not aborted");
  a_data_kind: assert property (acc_valid && !acc_fetch |=> !prefetch_abort)
    else $error("data access flagged as fetch abort");
  a_sram_gap: assert property (acc_valid && acc_addr inside {[SRAM_GAP_BASE:SRAM_GAP_END]}
    |=> resp_valid && (data_abort ^ prefetch_abort))
    else $error("sram gap not aborted");
  a_win_boot: assert property (acc_valid && map_mode == MAP_BOOT && acc_addr <= WIN_TOP
    |=> tgt_valid && tgt_addr == (BOOT_BASE | $past(acc_addr)))
    else $error("boot window remap wrong");
  a_win_ram: assert property (acc_valid && map_mode == MAP_RAM && acc_addr <= WIN_TOP
    |=> tgt_valid && tgt_addr == (SRAM_BASE | $past(acc_addr)))
    else $error("ram window remap wrong");
  a_boot_alias: assert property (acc_valid && acc_addr inside {[BOOT_BASE:32'h7FFF_FFFF]}
    |=> tgt_valid && tgt_addr == $past(acc_addr))
    else $error("boot block not at its own address");
  a_map_write: assert property (acc_valid && acc_write && !acc_fetch && acc_addr == MAP_SEL_ADDR
    && acc_wdata[1:0] == 2'h2 |=> map_mode == MAP_RAM)
    else $error("map select write not taken");
  a_low_gap: assert property (acc_valid && acc_addr inside {[FLASH_END_256K:RSV_LOW_END]}
    |=> resp_valid && !tgt_valid)
    else $error("space below sram not aborted");
  a_high_gap: assert property (acc_valid && acc_addr inside {[EXT_END + 32'h1:RSV_HIGH_END]}
    |=> resp_valid && !tgt_valid)
    else $error("space above external memory not aborted");
endmodule

bind vector_remap_abort_decoder vrad_checker chk_u (
  .mclk           (mclk),
  .reset          (reset),
  .acc_valid      (acc_valid),
  .acc_fetch      (acc_fetch),
  .acc_write      (acc_write),
  .acc_addr       (acc_addr),
  .acc_wdata      (acc_wdata),
  .tgt_valid      (tgt_valid),
  .tgt_addr       (tgt_addr),
  .resp_valid     (resp_valid),
  .data_abort     (data_abort),
  .prefetch_abort (prefetch_abort),
  .map_mode       (map_mode)
);

`default_nettype wire
